// ### logic/ddsl_defs.vh
// constants for the dual converter serial load interface
`ifndef DDSL_DEFS_VH
`define DDSL_DEFS_VH
`define DDSL_WORD_BITS    24
`define DDSL_DATA_BITS    16
`define DDSL_CNT_BITS     6
`define DDSL_RW_BIT       23
`define DDSL_TGT_HI       21
`define DDSL_TGT_LO       19
`define DDSL_CH_HI        18
`define DDSL_CH_LO        16
`define DDSL_TGT_FUNC     3'h0
`define DDSL_TGT_DATA     3'h2
`define DDSL_TGT_COARSE   3'h3
`define DDSL_TGT_FINE     3'h4
`define DDSL_FUNC_CLEAR   3'h4
`define DDSL_ZERO_CODE    16'h0000
`define DDSL_OB_ZERO      16'h8000
`define DDSL_SEG_BITS     4
`define DDSL_SEG_SW       15
`define DDSL_LADDER_BITS  12
`endif

// ### logic/ddsl_segdec.v
// thermometer decode of the upper data bits into segment switches
`timescale 1ns/1ps
`default_nettype none
`include "ddsl_defs.vh"
module ddsl_segdec
(
  // code from a dac register
  input  wire [`DDSL_DATA_BITS-1:0]  code,
  // segment and ladder switch controls
  output wire [`DDSL_SEG_SW-1:0]     seg_sw,
  output wire [`DDSL_LADDER_BITS-1:0] ladder_sw
);
  wire [`DDSL_SEG_BITS-1:0] top;
  assign top = code[`DDSL_DATA_BITS-1:`DDSL_LADDER_BITS];
  genvar i;
  generate
    for (i = 0; i < `DDSL_SEG_SW; i = i + 1)
    begin : g_seg
      assign seg_sw[i] = (top > i);
    end
  endgenerate
  assign ladder_sw = code[`DDSL_LADDER_BITS-1:0];
endmodule // ddsl_segdec
`default_nettype wire

// ### logic/ddsl_sync.v
// two-flop synchroniser for a single pin level
`timescale 1ns/1ps
`default_nettype none
module ddsl_sync
(
  // clock and reset
  input  wire clk,
  input  wire reset,
  // pin level and synchronised copy
  input  wire din,
  output wire dout
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end
  assign dout = sync_reg;
endmodule // ddsl_sync
`default_nettype wire

// ### logic/ddsl_top.v
// serial load interface of the dual converter
`timescale 1ns/1ps
`default_nettype none
`include "ddsl_defs.vh"
module ddsl_top
#(
  parameter CHANNELS = 2
)
(
  // clock and reset
  input  wire                          clk,
  input  wire                          reset,
  // serial link pins
  input  wire                          shift_clock,
  input  wire                          frame_select_n,
  input  wire                          serial_in_pin,
  output reg                           serial_out_pin,
  // control pins
  input  wire                          load_outputs_n,
  input  wire                          async_zero_pin,
  input  wire                          coding_select_pin,
  input  wire                          daisy_chain_en,
  // converter side
  output reg                           outputs_clamped,
  output wire [CHANNELS*16-1:0]        dac_code,
  output wire [CHANNELS*15-1:0]        dac_seg_sw,
  output wire [CHANNELS*12-1:0]        dac_ladder_sw,
  output reg  [CHANNELS*16-1:0]        coarse_gain,
  output reg  [CHANNELS*16-1:0]        fine_gain,
  output reg  [`DDSL_DATA_BITS-1:0]    function_reg,
  output reg                           word_error
);
  wire sck_s;
  wire fs_n_s;
  wire sdi_s;
  wire ld_n_s;
  wire zero_n_s;
  ddsl_sync u_s0 (
    .clk   (clk),
    .reset (reset),
    .din   (shift_clock),
    .dout  (sck_s)
  );
  ddsl_sync u_s1 (
    .clk   (clk),
    .reset (reset),
    .din   (~frame_select_n),
    .dout  (fs_n_s)
  );
  ddsl_sync u_s2 (
    .clk   (clk),
    .reset (reset),
    .din   (serial_in_pin),
    .dout  (sdi_s)
  );
  ddsl_sync u_s3 (
    .clk   (clk),
    .reset (reset),
    .din   (~load_outputs_n),
    .dout  (ld_n_s)
  );
  ddsl_sync u_s4 (
    .clk   (clk),
    .reset (reset),
    .din   (~async_zero_pin),
    .dout  (zero_n_s)
  );
  // coding pin only changes the analog meaning of a code,
  // so the register side never reads it

  // active-high copies after synchronising
  wire frame_on;
  wire load_on;
  wire zero_on;
  assign frame_on = fs_n_s;
  assign load_on  = ld_n_s;
  assign zero_on  = zero_n_s;

  reg sck_d_reg;
  reg frame_d_reg;
  reg load_d_reg;
  reg zero_d_reg;
  always @(posedge clk)
  begin
    if (reset)
    begin
      sck_d_reg   <= 1'b0;
      frame_d_reg <= 1'b0;
      load_d_reg  <= 1'b0;
      zero_d_reg  <= 1'b0;
    end
    else
    begin
      sck_d_reg   <= sck_s;
      frame_d_reg <= frame_on;
      load_d_reg  <= load_on;
      zero_d_reg  <= zero_on;
    end
  end
  wire sck_fall;
  wire sck_rise;
  wire frame_start;
  wire frame_end;
  wire load_fall;
  wire zero_fall;
  assign sck_fall    = sck_d_reg & ~sck_s;
  assign sck_rise    = ~sck_d_reg & sck_s;
  assign frame_start = frame_on & ~frame_d_reg;
  assign frame_end   = ~frame_on & frame_d_reg;
  assign load_fall   = load_on & ~load_d_reg;
  assign zero_fall   = zero_on & ~zero_d_reg;

  reg [`DDSL_WORD_BITS-1:0] shift_reg;
  reg [`DDSL_CNT_BITS-1:0]  count_reg;
  reg                       out_bit_reg;
  reg                       read_pend_reg;
  reg [`DDSL_DATA_BITS-1:0] read_data_reg;
  wire [`DDSL_CNT_BITS-1:0] word_bits;
  wire [31:0]               word_bits_full;
  assign word_bits_full = `DDSL_WORD_BITS;
  assign word_bits      = word_bits_full[`DDSL_CNT_BITS-1:0];

  // shift engine in the system clock domain
  always @(posedge clk)
  begin
    if (reset)
    begin
      shift_reg      <= {`DDSL_WORD_BITS{1'b0}};
      count_reg      <= {`DDSL_CNT_BITS{1'b0}};
      out_bit_reg    <= 1'b0;
      serial_out_pin <= 1'b0;
    end
    else if (frame_start)
    begin
      count_reg <= {`DDSL_CNT_BITS{1'b0}};
      if (read_pend_reg)
      begin
        shift_reg      <= {read_data_reg, {(`DDSL_WORD_BITS-16){1'b0}}};
        serial_out_pin <= read_data_reg[`DDSL_DATA_BITS-1];
      end
    end
    else if (frame_on)
    begin
      if (sck_fall)
      begin
        shift_reg   <= {shift_reg[`DDSL_WORD_BITS-2:0], sdi_s};
        // next bit out is the
        // new msb, so the chain delay is exactly one word
        out_bit_reg <= shift_reg[`DDSL_WORD_BITS-2];
        if (count_reg != {`DDSL_CNT_BITS{1'b1}})
          count_reg <= count_reg + 1'b1;
      end
      if (sck_rise)
        serial_out_pin <= out_bit_reg;
    end
  end

  // word validity: exact count, or any count of at least one word when chained
  wire count_ok;
  assign count_ok = daisy_chain_en ? (count_reg >= word_bits)
                                   : (count_reg == word_bits);
  wire                      commit;
  wire [2:0]                tgt;
  wire [2:0]                chan;
  wire [`DDSL_DATA_BITS-1:0] wdata;
  wire                      rd;
  assign commit = frame_end & count_ok;
  assign tgt    = shift_reg[`DDSL_TGT_HI:`DDSL_TGT_LO];
  assign chan   = shift_reg[`DDSL_CH_HI:`DDSL_CH_LO];
  assign wdata  = shift_reg[`DDSL_DATA_BITS-1:0];
  assign rd     = shift_reg[`DDSL_RW_BIT];

  reg [CHANNELS*16-1:0] input_reg;
  reg [CHANNELS*16-1:0] dac_reg;
  reg                   ld_during_reg;
  wire [`DDSL_DATA_BITS-1:0] clear_code;
  // zero code in either coding
  // 0 V or negative full scale follows from the pin outside
  assign clear_code = `DDSL_ZERO_CODE;
  wire soft_clear;
  assign soft_clear = commit & ~rd & (tgt == `DDSL_TGT_FUNC)
                      & (chan == `DDSL_FUNC_CLEAR);
  integer k;
  always @(posedge clk)
  begin
    if (reset)
    begin
      input_reg       <= {CHANNELS*16{1'b0}};
      dac_reg         <= {CHANNELS*16{1'b0}};
      coarse_gain     <= {CHANNELS*16{1'b0}};
      fine_gain       <= {CHANNELS*16{1'b0}};
      function_reg    <= `DDSL_ZERO_CODE;
      outputs_clamped <= 1'b1;
      ld_during_reg   <= 1'b0;
      read_pend_reg   <= 1'b0;
      read_data_reg   <= `DDSL_ZERO_CODE;
      word_error      <= 1'b0;
    end
    else
    begin
      if (frame_start)
        ld_during_reg <= load_on;
      if (frame_end)
        word_error <= ~count_ok;
      if (commit)
      begin
        read_pend_reg <= rd;
        for (k = 0; k < CHANNELS; k = k + 1)
        begin
          if (chan == k)
          begin
            if (rd)
              case (tgt)
                `DDSL_TGT_DATA:   read_data_reg <= input_reg[k*16 +: 16];
                `DDSL_TGT_COARSE: read_data_reg <= coarse_gain[k*16 +: 16];
                `DDSL_TGT_FINE:   read_data_reg <= fine_gain[k*16 +: 16];
                default:          read_data_reg <= function_reg;
              endcase
            else
              case (tgt)
                `DDSL_TGT_DATA:
                begin
                  input_reg[k*16 +: 16] <= wdata;
                  if (ld_during_reg & load_on)
                  begin
                    dac_reg[k*16 +: 16] <= wdata;
                    outputs_clamped     <= 1'b0;
                  end
                end
                `DDSL_TGT_COARSE: coarse_gain[k*16 +: 16] <= wdata;
                `DDSL_TGT_FINE:   fine_gain[k*16 +: 16]   <= wdata;
                default:          ;
              endcase
          end
        end
        if (~rd & (tgt == `DDSL_TGT_FUNC) & ~soft_clear)
          function_reg <= wdata;
      end
      if (zero_fall | soft_clear)
      begin
        dac_reg         <= {CHANNELS{clear_code}};
        input_reg       <= {CHANNELS{clear_code}};
        outputs_clamped <= 1'b0;
      end
      else if (load_fall & ~frame_on)
      begin
        dac_reg         <= input_reg;
        outputs_clamped <= 1'b0;
      end
    end
  end

  // per-channel segment decode
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : g_ch
      assign dac_code[g*16 +: 16] = dac_reg[g*16 +: 16];
      ddsl_segdec u_dec (
        .code      (dac_reg[g*16 +: 16]),
        .seg_sw    (dac_seg_sw[g*15 +: 15]),
        .ladder_sw (dac_ladder_sw[g*12 +: 12])
      );
    end
  endgenerate
endmodule // ddsl_top
`default_nettype wire

// ### tb/ddsl_host.sv
// host serial port model for the link pins
`timescale 1ns/1ps
`default_nettype none
module ddsl_host
(
  // link pins
  output var logic shift_clock,
  output var logic frame_select_n,
  output var logic serial_in_pin,
  input wire logic serial_out_pin
);
  logic [47:0] cap = 48'h0;
  initial
  begin
    shift_clock = 1'b1;
    frame_select_n = 1'b1;
    serial_in_pin = 1'b0;
  end
  task automatic send(input logic [47:0] w, input int n);
    frame_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in_pin = w[i];
      #200 shift_clock = 1'b0;
      cap = {cap[46:0], serial_out_pin};
      #200 shift_clock = 1'b1;
    end
    #200 frame_select_n = 1'b1;
    // released line shows no stale bit
    serial_in_pin = ~serial_in_pin;
    #400;
  endtask
endmodule // ddsl_host
`default_nettype wire

// ### tb/ddsl_props.sv
// checker for the serial load interface
`timescale 1ns/1ps
`default_nettype none
module ddsl_props
#(
  parameter CHANNELS = 2
)
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // link and control pins
  input wire logic                  shift_clock,
  input wire logic                  frame_select_n,
  input wire logic                  serial_out_pin,
  input wire logic                  load_outputs_n,
  input wire logic                  async_zero_pin,
  // converter side
  input wire logic                  outputs_clamped,
  input wire logic [CHANNELS*16-1:0] dac_code,
  input wire logic [CHANNELS*15-1:0] dac_seg_sw,
  input wire logic [CHANNELS*12-1:0] dac_ladder_sw,
  input wire logic [CHANNELS*16-1:0] coarse_gain,
  input wire logic [CHANNELS*16-1:0] fine_gain,
  input wire logic                  word_error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_rst; $fell(reset) |-> outputs_clamped && dac_code == '0; endproperty
  a_rst: assert property (p_rst)
    else $error("not zero or unclamped after reset");
  property p_lad; dac_ladder_sw[11:0] == dac_code[11:0]; endproperty
  a_lad: assert property (p_lad)
    else $error("ladder bits differ from code");
  property p_seg;
    dac_seg_sw[0] == (dac_code[15:12] != 4'h0) &&
    dac_seg_sw[14] == (dac_code[15:12] == 4'hf);
  endproperty
  a_seg: assert property (p_seg)
    else $error("segment decode wrong");
  property p_gst;
    $stable(frame_select_n) [*6] |=> $stable(coarse_gain) && $stable(fine_gain);
  endproperty
  a_gst: assert property (p_gst)
    else $error("gain changed without frame end");
  property p_dst;
    (load_outputs_n && async_zero_pin && frame_select_n) [*6] |=> $stable(dac_code);
  endproperty
  a_dst: assert property (p_dst)
    else $error("code changed without load");
  property p_zero; $fell(async_zero_pin) |-> ##[1:6] dac_code == '0; endproperty
  a_zero: assert property (p_zero)
    else $error("clear did not give zero code");
  property p_err; $rose(word_error) |-> $past(frame_select_n, 2); endproperty
  a_err: assert property (p_err)
    else $error("error flag raised inside frame");
  property p_sdo; $changed(serial_out_pin) |-> $past(shift_clock, 3); endproperty
  a_sdo: assert property (p_sdo)
    else $error("serial out moved off rising clock");
  cover property ($rose(word_error));
  cover property ($fell(outputs_clamped));
  cover property ($changed(serial_out_pin));
endmodule // ddsl_props
bind ddsl_top ddsl_props #(.CHANNELS(CHANNELS)) ddsl_props_inst (
  .clk(clk), .reset(reset), .shift_clock(shift_clock),
  .frame_select_n(frame_select_n), .serial_out_pin(serial_out_pin),
  .load_outputs_n(load_outputs_n), .async_zero_pin(async_zero_pin),
  .outputs_clamped(outputs_clamped), .dac_code(dac_code),
  .dac_seg_sw(dac_seg_sw), .dac_ladder_sw(dac_ladder_sw),
  .coarse_gain(coarse_gain), .fine_gain(fine_gain), .word_error(word_error));
`default_nettype wire

// ### tb/tb_ddsl_top.sv
// bench for the serial load interface
`timescale 1ns/1ps
`default_nettype none
module tb_ddsl_top;
  logic clk = 1'b0, reset = 1'b1, load_outputs_n = 1'b1;
  logic async_zero_pin = 1'b0, coding_select_pin = 1'b0;
  logic daisy_chain_en = 1'b0;
  wire shift_clock, frame_select_n, serial_in_pin, serial_out_pin;
  wire outputs_clamped, word_error;
  wire [31:0] dac_code, coarse_gain, fine_gain;
  wire [29:0] dac_seg_sw;
  wire [23:0] dac_ladder_sw;
  wire [15:0] function_reg;
  int num_errors = 0, n_tests = 0;
  always #25 clk = ~clk;
  ddsl_top ddsl_top_inst (.clk(clk), .reset(reset),
    .shift_clock(shift_clock), .frame_select_n(frame_select_n),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .load_outputs_n(load_outputs_n), .async_zero_pin(async_zero_pin),
    .coding_select_pin(coding_select_pin), .daisy_chain_en(daisy_chain_en),
    .outputs_clamped(outputs_clamped), .dac_code(dac_code),
    .dac_seg_sw(dac_seg_sw), .dac_ladder_sw(dac_ladder_sw),
    .coarse_gain(coarse_gain), .fine_gain(fine_gain),
    .function_reg(function_reg), .word_error(word_error));
  ddsl_host ddsl_host_inst (.shift_clock(shift_clock),
    .frame_select_n(frame_select_n), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin));
  task automatic check(input string s, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s exp %h seen %h", s, exp, got);
    end
  endtask
  task automatic final_report;
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_ld;
    load_outputs_n = 1'b0;
    clks(6);
    load_outputs_n = 1'b1;
    clks(6);
  endtask
  task automatic snd(input logic [47:0] w, input int n);
    ddsl_host_inst.send(w, n);
    clks(2);
  endtask
  function automatic logic [23:0] wd(input logic [2:0] t, c,
                                     input logic [15:0] d);
    return {2'b00, t, c, d};
  endfunction
  task automatic t_write;
    snd(wd(3'h2, 3'h0, 16'h9abc), 24);
    check("held", dac_code, 32'h0);
    pulse_ld();
    check("code", dac_code, 32'h9abc);
    check("seg", dac_seg_sw[14:0], 32'h1ff);
    check("ladder", dac_ladder_sw[11:0], 32'habc);
    check("clamp", outputs_clamped, 1'b0);
  endtask
  task automatic t_bad;
    snd(wd(3'h2, 3'h1, 16'h1234), 23);
    check("short", word_error, 1'b1);
    snd({wd(3'h2, 3'h1, 16'h1234), 1'b0}, 25);
    check("long", word_error, 1'b1);
    pulse_ld();
    check("dropped", dac_code, 32'h9abc);
  endtask
  task automatic t_regs;
    snd(wd(3'h3, 3'h1, 16'h5a5a), 24);
    check("coarse", coarse_gain, 32'h5a5a0000);
    snd(wd(3'h4, 3'h0, 16'hc3a5), 24);
    check("fine", fine_gain, 32'hc3a5);
    snd(wd(3'h0, 3'h0, 16'h0010), 24);
    check("func", function_reg, 32'h10);
    check("ok", word_error, 1'b0);
    load_outputs_n = 1'b0;
    snd(wd(3'h2, 3'h1, 16'h7777), 24);
    load_outputs_n = 1'b1;
    check("direct", dac_code, 32'h77779abc);
  endtask
  task automatic t_daisy;
    daisy_chain_en = 1'b1;
    snd({wd(3'h2, 3'h0, 16'h4321), wd(3'h3, 3'h0, 16'h2468)}, 48);
    check("chain out", ddsl_host_inst.cap[23:0], wd(3'h2, 3'h0, 16'h4321));
    check("last word", coarse_gain, 32'h5a5a2468);
    check("chain ok", word_error, 1'b0);
    daisy_chain_en = 1'b0;
  endtask
  task automatic t_read;
    logic hit;
    hit = 1'b0;
    snd(24'ha00000, 24);
    snd(24'h0, 24);
    for (int i = 0; i <= 8; i++)
      if (ddsl_host_inst.cap[i +: 16] === 16'hc3a5)
        hit = 1'b1;
    check("readback", hit, 1'b1);
  endtask
  task automatic t_zero;
    for (int c = 0; c < 2; c++)
    begin
      coding_select_pin = c[0];
      async_zero_pin = 1'b0;
      clks(8);
      async_zero_pin = 1'b1;
      check("zero", dac_code, 32'h0);
      pulse_ld();
      check("zero kept", dac_code, 32'h0);
      snd(wd(3'h2, 3'h0, 16'hffff), 24);
      pulse_ld();
    end
  endtask
  initial
  begin
    clks(10);
    async_zero_pin = 1'b1;
    clks(10);
    reset = 1'b0;
    clks(4);
    check("clamp", outputs_clamped, 1'b1);
    check("reset code", dac_code, 32'h0);
    t_write();
    t_bad();
    t_regs();
    t_daisy();
    t_read();
    t_zero();
    final_report();
  end
  initial
  begin
    #1ms;
    num_errors++;
    final_report();
  end
endmodule // tb_ddsl_top
`default_nettype wire
